// file: verilog/pcc_config.sv
// command, class code and revision registers with their enable gating
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module pcc_config
    import pcc_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // requests from the device datapaths
    input wire logic [7:0] BAR0_BASE,
    input wire logic [7:0] BAR1_BASE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic MEM_REQ,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_REQ,
    input wire logic PAL_ACCESS,
    input wire logic MASTER_REQ,
    input wire logic MASTER_WANT_INVAL,
    input wire logic ERROR_EVENT,
    input wire logic [1:0] VGA_GRAPHICS_MISC_MAP,
    // gated results
    output logic MEM_CLAIM,
    output logic IO_CLAIM,
    output logic PAL_SNOOP_ACT,
    output logic MASTER_START,
    output logic MASTER_USE_INVAL,
    output logic SYSTEM_ERROR_DRIVER_EN_OUT,
    output logic SYSTEM_ERROR_OE
);
    pcc_state_s s_q, s_d;
    pcc_ctrl_s c;
    logic [31:0] vga_lo, vga_hi;
    logic vga_hit, bar_hit, io_hit;
    logic [9:0] io_low;

    assign c.io_en = s_q.command[PCC_BIT_IO_SPACE];
    assign c.mem_en = s_q.command[PCC_BIT_MEM_SPACE];
    assign c.master_en = s_q.command[PCC_BIT_BUS_MASTER];
    assign c.wr_inval_en = s_q.command[PCC_BIT_WR_INVAL];
    assign c.pal_snoop = s_q.command[PCC_BIT_PAL_SNOOP];
    assign c.serr_en = s_q.command[PCC_BIT_SERR_EN];

    // vga memory window chosen by misc map select
    always_comb begin
        case (VGA_GRAPHICS_MISC_MAP)
            2'b00: begin
                vga_lo = 32'h000A0000;
                vga_hi = 32'h000BFFFF;
            end
            2'b01: begin
                vga_lo = 32'h000A0000;
                vga_hi = 32'h000AFFFF;
            end
            2'b10: begin
                vga_lo = 32'h000B0000;
                vga_hi = 32'h000B7FFF;
            end
            default: begin
                vga_lo = 32'h000B8000;
                vga_hi = 32'h000BFFFF;
            end
        endcase
    end

    assign vga_hit = (MEM_ADDR >= vga_lo) && (MEM_ADDR <= vga_hi);
    assign bar_hit = (MEM_ADDR[31:24] == (BAR0_BASE & PCC_BAR_MASK))
        || (MEM_ADDR[31:24] == (BAR1_BASE & PCC_BAR_MASK));
    // aliases repeat every 1k, so only the low ten bits are compared
    assign io_low = IO_ADDR[9:0] & PCC_IO_ALIAS_MASK;
    assign io_hit = (io_low >= PCC_VGA_LO0[9:0] && io_low <= PCC_VGA_HI0[9:0])
        || (io_low >= PCC_VGA_LO1[9:0] && io_low <= PCC_VGA_HI1[9:0]);

    assign MEM_CLAIM = MEM_REQ && c.mem_en && (bar_hit || vga_hit);
    assign IO_CLAIM = IO_REQ && c.io_en && io_hit;
    assign PAL_SNOOP_ACT = PAL_ACCESS && c.pal_snoop;
    assign MASTER_START = MASTER_REQ && c.master_en;
    assign MASTER_USE_INVAL = MASTER_START && MASTER_WANT_INVAL
        && c.wr_inval_en;
    assign SYSTEM_ERROR_DRIVER_EN_OUT = c.serr_en;
    assign SYSTEM_ERROR_OE = ERROR_EVENT && c.serr_en;
    assign RDATA = s_q.rdata;

    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h00000000;
        if (WR && ADDR == PCC_OFS_COMMAND) begin
            // only writable bits land; others stay zero
            s_d.command = WDATA[15:0] & PCC_CMD_WMASK;
        end
        if (RD) begin
            case (ADDR)
                PCC_OFS_COMMAND: s_d.rdata = {16'h0000, s_q.command};
                // dword at 08: class in 31:8, base class on top
                PCC_OFS_REVISION: s_d.rdata = {PCC_CLASS_VALUE, REVISION};
                // byte-offset reads of class land the low byte at bit 0
                PCC_OFS_CLASS: s_d.rdata = {8'h00, PCC_CLASS_VALUE};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_q.command <= PCC_CMD_RESET;
            s_q.rdata <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    AST_SERR_GATED: assert property (@(posedge CORE_CLK) disable iff (RST)
        SYSTEM_ERROR_OE |-> s_q.command[PCC_BIT_SERR_EN])
        else $error("error driver enabled with bit 8 clear");
    AST_SNOOP: assert property (@(posedge CORE_CLK) disable iff (RST)
        PAL_SNOOP_ACT == (PAL_ACCESS && s_q.command[5]))
        else $error("palette snoop gating wrong");
    AST_INVAL: assert property (@(posedge CORE_CLK) disable iff (RST)
        MASTER_USE_INVAL |-> s_q.command[4])
        else $error("invalidate without bit 4");
    AST_MASTER: assert property (@(posedge CORE_CLK) disable iff (RST)
        !s_q.command[2] |-> !MASTER_START)
        else $error("master start while disabled");
    AST_MEM: assert property (@(posedge CORE_CLK) disable iff (RST)
        !s_q.command[1] |-> !MEM_CLAIM)
        else $error("memory claimed while disabled");
    AST_IO: assert property (@(posedge CORE_CLK) disable iff (RST)
        !s_q.command[0] |-> !IO_CLAIM)
        else $error("io claimed while disabled");
    AST_CLASS: assert property (@(posedge CORE_CLK) disable iff (RST)
        RD && ADDR == 8'h08 |=> RDATA[31:8] == 24'h030000)
        else $error("class value wrong");
    AST_RSVD: assert property (@(posedge CORE_CLK) disable iff (RST)
        RD && ADDR == 8'h04 |=> (RDATA & 32'hFFFFFEC8) == 0)
        else $error("reserved command bits nonzero");
    AST_REV: assert property (@(posedge CORE_CLK) disable iff (RST)
        RD && ADDR == 8'h08 |=> RDATA[7:0] == REVISION)
        else $error("revision wrong");
    AST_WR: assert property (@(posedge CORE_CLK) disable iff (RST)
        WR && ADDR != 8'h04 |=> $stable(s_q.command))
        else $error("command changed by other write");
endmodule : pcc_config

// file: verilog/pcc_pkg.sv
// package for the configuration command, class and revision block
package pcc_pkg;
    // byte offsets
    localparam logic [7:0] PCC_OFS_COMMAND = 8'h04;
    localparam logic [7:0] PCC_OFS_REVISION = 8'h08;
    localparam logic [7:0] PCC_OFS_CLASS = 8'h09;
    // command bit positions
    localparam int PCC_BIT_IO_SPACE = 0;
    localparam int PCC_BIT_MEM_SPACE = 1;
    localparam int PCC_BIT_BUS_MASTER = 2;
    localparam int PCC_BIT_WR_INVAL = 4;
    localparam int PCC_BIT_PAL_SNOOP = 5;
    localparam int PCC_BIT_SERR_EN = 8;
    localparam logic [15:0] PCC_CMD_WMASK = 16'h0137;
    localparam logic [15:0] PCC_CMD_RESET = 16'h0000;
    localparam logic [23:0] PCC_CLASS_VALUE = 24'h030000;
    // vga windows
    localparam logic [15:0] PCC_VGA_LO0 = 16'h03B0;
    localparam logic [15:0] PCC_VGA_HI0 = 16'h03BB;
    localparam logic [15:0] PCC_VGA_LO1 = 16'h03C0;
    localparam logic [15:0] PCC_VGA_HI1 = 16'h03DF;
    localparam logic [9:0] PCC_IO_ALIAS_MASK = 10'h3FF;
    localparam logic [7:0] PCC_BAR_MASK = 8'hFF;

    typedef struct packed {
        logic [15:0] command;
        logic [31:0] rdata;
    } pcc_state_s;

    typedef struct packed {
        logic io_en;
        logic mem_en;
        logic master_en;
        logic wr_inval_en;
        logic pal_snoop;
        logic serr_en;
    } pcc_ctrl_s;
endpackage : pcc_pkg

// file: tb/pcc_host.sv
// host bridge model issuing configuration accesses
`timescale 1ns/1ps
module pcc_host (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata
);
    initial begin
        addr = 8'hFF;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a; // released bus shows no stale value
        wdata <= ~d;
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        d = rdata;
    endtask : cfg_rd
endmodule : pcc_host

// file: tb/pcc_config_test.sv
// self-checking bench for the command, class and revision block
`timescale 1ns/1ps
module pcc_config_test;
    import pcc_pkg::*;
    localparam logic [7:0] REV = 8'hC3; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] a, b0, b1;
    logic [31:0] wd, rdat, rv, ma;
    logic w, r, mq, iq, pa, mr, mi, ev;
    logic [15:0] ia;
    logic [1:0] vm;
    logic [6:0] o;
    int errors = 0;
    int cmp_count = 0;
    int bits [6] = '{0, 1, 2, 4, 5, 8};
    logic [6:0] exp_o [6] = '{7'h01, 7'h02, 7'h04, 7'h00, 7'h08, 7'h60};
    always #50 clk = ~clk;
    pcc_host host_u (.clk(clk), .addr(a), .wdata(wd), .wr(w), .rd(r),
        .rdata(rdat));
    pcc_config #(.REVISION(REV)) dut_u (.CORE_CLK(clk), .RST(rst),
        .ADDR(a), .WDATA(wd), .WR(w), .RD(r), .RDATA(rdat),
        .BAR0_BASE(b0), .BAR1_BASE(b1), .MEM_ADDR(ma), .MEM_REQ(mq),
        .IO_ADDR(ia), .IO_REQ(iq), .PAL_ACCESS(pa), .MASTER_REQ(mr),
        .MASTER_WANT_INVAL(mi), .ERROR_EVENT(ev),
        .VGA_GRAPHICS_MISC_MAP(vm), .MEM_CLAIM(o[1]), .IO_CLAIM(o[0]),
        .PAL_SNOOP_ACT(o[3]), .MASTER_START(o[2]),
        .MASTER_USE_INVAL(o[4]), .SYSTEM_ERROR_DRIVER_EN_OUT(o[6]),
        .SYSTEM_ERROR_OE(o[5]));
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
        host_u.cfg_rd(ad, rv);
        chk("read data", e, rv);
    endtask : rd_chk
    // memory decode case: map, address, expected claim
    task automatic mem_case(input logic [1:0] m, input logic [31:0] ad,
        input logic e);
        @(posedge clk);
        vm <= m;
        ma <= ad;
        @(negedge clk);
        chk("memory claim", {31'h0, e}, {31'h0, o[1]});
    endtask : mem_case
    task automatic test_done;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    initial begin
        {mq, iq, pa, mr, mi, ev} = 6'h3F;
        b0 = 8'h12;
        b1 = 8'h34;
        ma = 32'h000A0000;
        ia = 16'h07C5; // alias of 0x3C5
        vm = 2'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h04, 32'h0);
        chk("gates idle", 32'h0, {25'h0, o});
        for (int i = 0; i < 6; i++) begin
            host_u.cfg_wr(8'h04, 32'h1 << bits[i]);
            @(negedge clk);
            chk("gates", {25'h0, exp_o[i]}, {25'h0, o});
            rd_chk(8'h04, 32'h1 << bits[i]);
        end
        host_u.cfg_wr(8'h04, 32'hFFFFFFFF);
        rd_chk(8'h04, 32'h00000137);
        chk("all gates", 32'h7F, {25'h0, o});
        mem_case(2'h1, 32'h000B0000, 1'b0);
        mem_case(2'h2, 32'h000B0000, 1'b1);
        mem_case(2'h3, 32'h000A0000, 1'b0);
        mem_case(2'h3, 32'h34FFFFFF, 1'b1);
        @(posedge clk);
        ia <= 16'h03BC;
        @(negedge clk);
        chk("io gap", 32'h0, {31'h0, o[0]});
        host_u.cfg_wr(8'h08, 32'hFFFFFFFF);
        host_u.cfg_wr(8'h09, 32'h0);
        rd_chk(8'h08, {24'h030000, REV});
        rd_chk(8'h09, 32'h00030000);
        rd_chk(8'h10, 32'h0);
        host_u.cfg_wr(8'h04, 32'h0);
        @(negedge clk);
        chk("gates off", 32'h0, {25'h0, o});
        test_done;
    end
endmodule : pcc_config_test
